// File: pm_defs.svh
// Constants for the standby mode controller: register offsets, bit fields, resets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB
`define PM_OFS_CTRL      8'h00
`define PM_OFS_MODE      8'h04
`define PM_OFS_STAT      8'h08

// ==========================================================================
// Control register fields
`define PM_CTRL_ENTRY    0
`define PM_CTRL_INTBLK   1
`define PM_CTRL_NMIBLK   2
`define PM_CTRL_WD2BLK   3
`define PM_CTRL_RST      4'h0

// ==========================================================================
// Mode register fields
`define PM_MODE_DEPTH    0
`define PM_MODE_SUBOFF   7
`define PM_MODE_RST      8'h00

// ==========================================================================
// Status register fields and widths
`define PM_STAT_STATE_LO 0
`define PM_STAT_STATE_HI 1
`define PM_STAT_ACK      2
`define PM_NUM_EXT       8
`define PM_NUM_SYNC      9

`endif

// File: pm_pkg.sv
// Types shared by the standby mode controller files.
// Assumes pm_defs.svh sits in the include path.
`include "pm_defs.svh"

package pm_pkg;

   // ==========================================================================
   // Controller states.
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_HALT = 2'b01,
      ST_IDLE = 2'b10
   } pm_state_t;

endpackage

// File: pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes pins are levels that stay stable for several pclk periods.
`timescale 1ns/100ps

module pin_sync #(
   parameter int WIDTH = 1                     // Number of pins.
) (
   input  wire logic             pclk,         // System clock.
   input  wire logic             presetn,      // Asynchronous reset, active low.
   input  wire logic [WIDTH-1:0] pin_in,       // Raw pin levels.
   output logic      [WIDTH-1:0] pin_sync_out  // Synchronised levels.
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // ==========================================================================
   // The first stage feeds only the second stage, to contain metastability.
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pin_sync_out = sync_q;

endmodule

// File: pm_apb_regs.sv
// APB register file of the standby mode controller: control, mode and status.
// Assumes a zero-wait APB master on pclk; the controller core clears entry.
`timescale 1ns/100ps
`include "pm_defs.svh"

module pm_apb_regs (
   input  wire logic        pclk,          // System clock.
   input  wire logic        presetn,       // Asynchronous reset, active low.
   input  wire logic        soft_rst,      // Ordinary reset request, synchronous.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB access phase.
   input  wire logic        pwrite,        // APB direction.
   input  wire logic [7:0]  paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   output logic      [31:0] prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error, unmapped address.
   input  wire logic        entry_clr,     // Controller clears standby entry.
   input  wire logic [2:0]  stat_in,       // Controller state and ack flag.
   output logic [3:0]       ctrl_q,        // Control register.
   output logic [7:0]       mode_q         // Mode register.
);

   logic [3:0]  ctrl_d;
   logic [7:0]  mode_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        acc;
   logic        hit;

   // ==========================================================================
   // Zero-wait slave. Read data are registered at the setup edge, so prdata stands
   // from a flip-flop while pready is high; status read is one cycle old.
   assign acc     = psel && penable;
   assign hit     = (paddr == `PM_OFS_CTRL) || (paddr == `PM_OFS_MODE) ||
                    (paddr == `PM_OFS_STAT);
   assign pready  = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata  = prdata_q;

   // Next register values; a hardware clear of entry loses to a software set.
   always_comb begin
      ctrl_d   = ctrl_q;
      mode_d   = mode_q;
      prdata_d = prdata_q;
      if (entry_clr) begin
         ctrl_d[`PM_CTRL_ENTRY] = 1'b0;
      end
      if (acc && pwrite && paddr == `PM_OFS_CTRL) begin
         ctrl_d = pwdata[3:0];
      end
      if (acc && pwrite && paddr == `PM_OFS_MODE) begin
         mode_d = pwdata[7:0];
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `PM_OFS_CTRL: prdata_d = {28'h0000000, ctrl_q};
            `PM_OFS_MODE: prdata_d = {24'h000000, mode_q};
            `PM_OFS_STAT: prdata_d = {29'h0000000, stat_in};
            default:      prdata_d = 32'h00000000;
         endcase
      end
      if (soft_rst) begin
         ctrl_d = `PM_CTRL_RST;
         mode_d = `PM_MODE_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= `PM_CTRL_RST;
         mode_q   <= `PM_MODE_RST;
         prdata_q <= 32'h00000000;
      end else begin
         ctrl_q   <= ctrl_d;
         mode_q   <= mode_d;
         prdata_q <= prdata_d;
      end
   end

endmodule

// File: pm_ctrl.sv
// Standby mode controller: HALT and IDLE sequencing with clock-enable outputs.
// Assumes core, interrupt controller and reset controller share pclk.
//
// How it works
// - Halt instruction stops only the processor clock; peripherals keep running (code also gates watch timer and watchdog two per the timer rules below).
// - Reset during HALT is just the ordinary reset.
// - Port pins hold level and direction throughout HALT.
// - Registers, flags and RAM are retained across HALT.
// - Watch timer runs in HALT if subclock used or main-clock sourced.
// - Second watchdog runs in HALT if subclock used or ring/8 sourced.
// - Entry bit set with depth select zero enters IDLE.
// - Depth select one means STOP; it counts only with entry set.
// - IDLE stops processor and peripheral clocks; oscillator keeps running.
// - In IDLE subclock, ring and external domains run; RAM kept.
// - Leaving IDLE restores clocks at once, no stabilisation wait.
// - NMI pin, watchdog two, unmasked pins or idle peripherals wake IDLE.
// - All resets but watchdog one release IDLE.
// - After IDLE release, normal clocking of everything returns.
// - Lower priority request only wakes; higher or NMI is also acknowledged.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pm_defs.svh"

module pm_ctrl (
   input  wire logic        pclk,               // System clock, 20 MHz.
   input  wire logic        presetn,            // Asynchronous reset, active low.
   input  wire logic        psel,               // APB select.
   input  wire logic        penable,            // APB access phase.
   input  wire logic        pwrite,             // APB direction.
   input  wire logic [7:0]  paddr,              // APB byte address.
   input  wire logic [31:0] pwdata,             // APB write data.
   output logic      [31:0] prdata,             // APB read data.
   output logic             pready,             // APB ready.
   output logic             pslverr,            // APB error.
   input  wire logic        halt_instr,         // Core executes halt, one pulse.
   input  wire logic        nmi_pin,            // NMI pin, asynchronous.
   input  wire logic [7:0]  external_irq_pins,  // External interrupt pins.
   input  wire logic [7:0]  ext_irq_mask,       // Mask per pin, 1 masks.
   input  wire logic        watchdog_two_nmi_request, // Watchdog two NMI.
   input  wire logic        wdt1_nmi,           // Watchdog one NMI.
   input  wire logic        irq_pending,        // Any unmasked maskable request.
   input  wire logic        idle_periph_irq,    // Unmasked idle-capable request.
   input  wire logic        req_higher_prio,    // Request outranks current one.
   input  wire logic        other_reset_req,    // Any reset but watchdog one.
   input  wire logic        watchdog_one_reset, // Watchdog one reset.
   input  wire logic        wt_src_main,        // Watch timer counts main clock.
   input  wire logic        wdt2_src_ring_div8, // Watchdog two counts ring/8.
   output logic             cpu_clk_en_q,       // Processor clock enable.
   output logic             periph_clk_en_q,    // Peripheral clock enable.
   output logic             wt_clk_en_q,        // Watch timer clock enable.
   output logic             wdt2_clk_en_q,      // Watchdog two clock enable.
   output logic             port_hold_q,        // Freeze port pins.
   output logic             ram_retain_q,       // Hold RAM and core state.
   output logic             stop_request_q,     // STOP asked for, one pulse.
   output logic             wake_ack_q,         // Wake request acknowledged.
   output logic             wake_only_q,        // Wake without acknowledge.
   output logic             sys_reset_q         // Ordinary reset to the chip.
);
   import pm_pkg::*;

   pm_state_t  state_q;
   pm_state_t  state_d;
   logic [3:0] ctrl_q;
   logic [7:0] mode_q;
   logic [8:0] pins_s;
   logic       entry;
   logic       depth;
   logic       sub_off;
   logic       nmi_s;
   logic [7:0] ext_s;
   logic       nmi_any;
   logic       halt_wake;
   logic       idle_wake;
   logic       release_ev;
   logic       soft_rst;
   logic       entry_clr;
   logic       cpu_d;
   logic       per_d;
   logic       wt_d;
   logic       wd2_d;
   logic       hold_d;
   logic       stop_d;
   logic       ack_d;
   logic       only_d;
   logic       srst_d;

   // ==========================================================================
   // Pin synchronisers and register file.
   pin_sync #(
      .WIDTH (`PM_NUM_SYNC)
   ) u_sync (
      .pclk         (pclk),
      .presetn      (presetn),
      .pin_in       ({nmi_pin, external_irq_pins}),
      .pin_sync_out (pins_s)
   );

   pm_apb_regs u_regs (
      .pclk      (pclk),
      .presetn   (presetn),
      .soft_rst  (soft_rst),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .entry_clr (entry_clr),
      .stat_in   ({wake_ack_q, state_q}),
      .ctrl_q    (ctrl_q),
      .mode_q    (mode_q)
   );

   // ==========================================================================
   // Release sources.
   assign nmi_s   = pins_s[`PM_NUM_EXT];
   assign ext_s   = pins_s[`PM_NUM_EXT-1:0];
   assign entry   = ctrl_q[`PM_CTRL_ENTRY];
   assign depth   = mode_q[`PM_MODE_DEPTH];
   assign sub_off = mode_q[`PM_MODE_SUBOFF];

   // Block bits let software keep a held request from cancelling entry.
   assign nmi_any   = (nmi_s && !ctrl_q[`PM_CTRL_NMIBLK]) ||
                      (watchdog_two_nmi_request && !ctrl_q[`PM_CTRL_WD2BLK]);
   assign halt_wake = nmi_s || watchdog_two_nmi_request || wdt1_nmi || irq_pending;
   assign idle_wake = nmi_any || (!ctrl_q[`PM_CTRL_INTBLK] &&
                      ((|(ext_s & ~ext_irq_mask)) || idle_periph_irq));

   // Watchdog one is stopped in IDLE and must not release it.
   assign soft_rst = other_reset_req ||
                     (watchdog_one_reset && state_q != ST_IDLE);

   assign release_ev = (state_q == ST_HALT && halt_wake) ||
                       (state_q == ST_IDLE && idle_wake);

   // ==========================================================================
   // Mode sequencer. Reset in any state is the plain reset path.
   always_comb begin
      state_d   = state_q;
      entry_clr = 1'b0;
      stop_d    = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (entry && !depth) begin
               state_d   = ST_IDLE;
            end else if (entry && depth) begin
               stop_d    = 1'b1;
               entry_clr = 1'b1;
            end else if (halt_instr) begin
               state_d   = ST_HALT;
            end
         end
         ST_HALT: begin
            if (halt_wake) begin
               state_d = ST_RUN;
            end
         end
         ST_IDLE: begin
            if (idle_wake) begin
               state_d   = ST_RUN;
               entry_clr = 1'b1;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      if (soft_rst) begin
         state_d   = ST_RUN;
         entry_clr = 1'b0;
         stop_d    = 1'b0;
      end
   end

   // ==========================================================================
   // Output enables follow the next state so they switch with it, glitch free.
   always_comb begin
      cpu_d  = (state_d == ST_RUN);
      per_d  = (state_d != ST_IDLE);
      hold_d = (state_d != ST_RUN);
      // Outside RUN both timers depend on the subclock and source choice.
      wt_d   = (state_d == ST_RUN) || !sub_off || wt_src_main;
      wd2_d  = (state_d == ST_RUN) || !sub_off || wdt2_src_ring_div8;
      ack_d  = release_ev && !soft_rst && (nmi_s || watchdog_two_nmi_request ||
               wdt1_nmi || req_higher_prio);
      only_d = release_ev && !soft_rst && !ack_d;
      srst_d = soft_rst;
   end

   // No wait state on release: the oscillator never stopped.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q         <= ST_RUN;
         cpu_clk_en_q    <= 1'b1;
         periph_clk_en_q <= 1'b1;
         wt_clk_en_q     <= 1'b1;
         wdt2_clk_en_q   <= 1'b1;
         port_hold_q     <= 1'b0;
         ram_retain_q    <= 1'b0;
         stop_request_q  <= 1'b0;
         wake_ack_q      <= 1'b0;
         wake_only_q     <= 1'b0;
         sys_reset_q     <= 1'b0;
      end else begin
         state_q         <= state_d;
         cpu_clk_en_q    <= cpu_d;
         periph_clk_en_q <= per_d;
         wt_clk_en_q     <= wt_d;
         wdt2_clk_en_q   <= wd2_d;
         port_hold_q     <= hold_d;
         ram_retain_q    <= hold_d;
         stop_request_q  <= stop_d;
         wake_ack_q      <= ack_d;
         wake_only_q     <= only_d;
         sys_reset_q     <= srst_d;
      end
   end

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // HALT gates the processor, not the peripherals.
   a_halt_cpu_off: assert property (state_q == ST_HALT |->
      !cpu_clk_en_q && periph_clk_en_q) else $error("halt clocks wrong");

   // A halt pulse with no entry pending.
   a_halt_entry: assert property (
      state_q == ST_RUN && halt_instr && !entry && !soft_rst |=> state_q == ST_HALT)
      else $error("halt not entered");

   // HALT wake restores clocks at once.
   a_halt_wake: assert property (
      state_q == ST_HALT && halt_wake |=> state_q == ST_RUN && cpu_clk_en_q)
      else $error("halt not released");

   // Ordinary reset from any state.
   a_reset_to_run: assert property (soft_rst |=>
      state_q == ST_RUN && cpu_clk_en_q && sys_reset_q) else $error("reset path");

   // Pins and core state held in standby.
   a_hold_ports: assert property (state_q != ST_RUN |->
      port_hold_q && ram_retain_q) else $error("ports not held");

   // Watch timer gate outside RUN.
   a_wt_gate: assert property (state_q != ST_RUN |->
      wt_clk_en_q == (!$past(sub_off) || $past(wt_src_main)))
      else $error("watch timer gate");

   // Watchdog two gate in steady HALT.
   a_wdt2_gate: assert property (
      state_q == ST_HALT && $past(state_q) == ST_HALT |->
      wdt2_clk_en_q == (!$past(sub_off) || $past(wdt2_src_ring_div8)))
      else $error("watchdog two gate");

   // Entry with depth zero.
   a_idle_entry: assert property (
      state_q == ST_RUN && entry && !depth && !soft_rst |=>
      state_q == ST_IDLE ##0 !cpu_clk_en_q && !periph_clk_en_q)
      else $error("idle not entered");

   // Entry with depth one.
   a_stop_select: assert property (
      state_q == ST_RUN && entry && depth && !soft_rst |=>
      stop_request_q && state_q == ST_RUN ##1 !stop_request_q)
      else $error("stop select");

   // Depth select alone does nothing.
   a_depth_alone: assert property (!entry |=> !stop_request_q)
      else $error("depth acted without entry");

   // IDLE gates both domains.
   a_idle_off: assert property (state_q == ST_IDLE |->
      !cpu_clk_en_q && !periph_clk_en_q) else $error("idle clocks on");

   // Subclock in use keeps timers running.
   a_idle_timers: assert property (
      state_q == ST_IDLE && !$past(sub_off) |-> wt_clk_en_q && wdt2_clk_en_q)
      else $error("idle timers stopped");

   // IDLE wake restores clocks at once.
   a_idle_wake: assert property (
      state_q == ST_IDLE && idle_wake |=>
      state_q == ST_RUN && cpu_clk_en_q && periph_clk_en_q)
      else $error("idle not released");

   // RUN keeps the processor and peripheral clocks on and the ports free.
   a_run_clocks: assert property (state_q == ST_RUN |->
      cpu_clk_en_q && periph_clk_en_q && !port_hold_q) else $error("run clocks off");

   // Watchdog one reset ignored in IDLE.
   a_wdt1_ignored: assert property (
      state_q == ST_IDLE && watchdog_one_reset && !other_reset_req && !idle_wake |=>
      state_q == ST_IDLE && !sys_reset_q) else $error("watchdog one released idle");

   // Low-priority wake is not acknowledged.
   a_wake_ack: assert property (
      release_ev && !soft_rst && !req_higher_prio && !nmi_s &&
      !watchdog_two_nmi_request && !wdt1_nmi |=> wake_only_q && !wake_ack_q)
      else $error("low priority acknowledged");

   c_halt_cycle: cover property (state_q == ST_RUN ##1 state_q == ST_HALT
      ##[1:20] state_q == ST_RUN);
   c_idle_by_pin: cover property (state_q == ST_IDLE && |(ext_s & ~ext_irq_mask)
      ##1 state_q == ST_RUN);
   c_stop_req: cover property (stop_request_q);
   c_reset_in_halt: cover property (state_q == ST_HALT && other_reset_req);
   c_wake_acked: cover property (wake_ack_q && state_q == ST_RUN);

endmodule

// File: core_model.sv
// Behavioural processor core that faces the standby mode controller.
// Assumes the controller's processor clock enable gates every step it takes.
`timescale 1ns/100ps

module core_model (
   input  wire logic        pclk,        // System clock.
   input  wire logic        presetn,     // Reset, active low.
   input  wire logic        cpu_en,      // Processor clock enable.
   input  wire logic        halt_go,     // Bench asks for a halt instruction.
   output logic             halt_instr,  // Halt executed, one pulse.
   output logic [15:0]      step_cnt     // Instructions retired.
);
   // ======================================================================
   // Instruction stream
   // One instruction retires per enabled clock. A gated core cannot execute,
   // so the halt pulse is only issued while clocked and never twice in a row.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_instr <= 1'b0;
         step_cnt   <= 16'h0000;
      end else begin
         halt_instr <= halt_go & cpu_en & ~halt_instr;
         if (cpu_en) begin
            step_cnt <= step_cnt + 16'h0001;
         end
      end
   end
endmodule

// File: halt_idle_power_mode_ctrl_tb.sv
// Bench for the standby mode controller: APB tasks and HALT/IDLE scenarios.
// Assumes pm_defs.svh, pm_pkg, pm_ctrl and core_model are compiled first.
`timescale 1ns/100ps
`include "pm_defs.svh"

module halt_idle_power_mode_ctrl_tb;
   import pm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_go, err;
   logic [7:0]  paddr, external_irq_pins, ext_irq_mask;
   logic [31:0] pwdata, prdata, rd;
   logic        nmi_pin, watchdog_two_nmi_request, wdt1_nmi, irq_pending, idle_periph_irq;
   logic        req_higher_prio, other_reset_req, watchdog_one_reset, wt_src_main;
   logic        wdt2_src_ring_div8, halt_instr, cpu_clk_en_q, periph_clk_en_q, wt_clk_en_q;
   logic        wdt2_clk_en_q, port_hold_q, ram_retain_q, stop_request_q, wake_ack_q;
   logic        wake_only_q, sys_reset_q;
   logic [15:0] step_cnt, snap;
   int          fails, checks_done, n_ack, n_only, n_stop;

   pm_ctrl dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .halt_instr, .nmi_pin, .external_irq_pins, .ext_irq_mask,
      .watchdog_two_nmi_request, .wdt1_nmi, .irq_pending, .idle_periph_irq,
      .req_higher_prio, .other_reset_req, .watchdog_one_reset, .wt_src_main,
      .wdt2_src_ring_div8, .cpu_clk_en_q, .periph_clk_en_q, .wt_clk_en_q,
      .wdt2_clk_en_q, .port_hold_q, .ram_retain_q, .stop_request_q, .wake_ack_q,
      .wake_only_q, .sys_reset_q
   );
   core_model core (
      .pclk, .presetn, .cpu_en(cpu_clk_en_q), .halt_go, .halt_instr, .step_cnt
   );

   // ======================================================================
   // Clock and pulse counters
   // The clock runs at 20 MHz.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Registered pulses stand one cycle, so each is counted once per edge.
   always @(posedge pclk) begin
      n_ack  += (wake_ack_q === 1'b1);
      n_only += (wake_only_q === 1'b1);
      n_stop += (stop_request_q === 1'b1);
   end

   // ======================================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; response and read data are taken at the access edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      rd  = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Waits a bounded time for the processor enable to reach a level.
   task automatic wait_cpu(input logic e, input int lim);
      int n;
      n = 0;
      while (cpu_clk_en_q !== e && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk(cpu_clk_en_q, e, "processor clock enable");
   endtask

   task automatic do_halt;
      halt_go <= 1'b1;
      @(posedge pclk);
      halt_go <= 1'b0;
      wait_cpu(1'b0, 6);
      @(posedge pclk);
   endtask

   // The core owes five idle slots after the entry store; they are waited out.
   task automatic go_idle(input logic [7:0] m, input logic [3:0] c);
      apb(1'b1, `PM_OFS_MODE, {24'h0, m});
      apb(1'b1, `PM_OFS_CTRL, {28'h0, c});
      wait_cpu(1'b0, 6);
      repeat (5) @(posedge pclk);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ======================================================================
   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      #250000;
      fails++;
      results;
   end

   // ======================================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, halt_go, nmi_pin, watchdog_two_nmi_request} = '0;
      {wdt1_nmi, irq_pending, idle_periph_irq, req_higher_prio, other_reset_req} = '0;
      {watchdog_one_reset, wt_src_main, wdt2_src_ring_div8} = '0;
      {paddr, external_irq_pins, pwdata} = '0;
      ext_irq_mask = 8'h01;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `PM_OFS_STAT, 32'h0);
      chk(rd, 32'h0, "status after reset");
      apb(1'b0, 8'h0C, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
      apb(1'b1, `PM_OFS_MODE, 32'h80);
      apb(1'b0, `PM_OFS_MODE, 32'h0);
      chk(rd, 32'h80, "mode readback");
      // HALT with the subclock unused, every pair of count-clock sources.
      for (int k = 0; k < 4; k++) begin
         {wt_src_main, wdt2_src_ring_div8} <= 2'(k);
         do_halt;
         chk(periph_clk_en_q, 1'b1, "peripheral enable in halt");
         chk(wt_clk_en_q, k[1], "watch timer enable");
         chk(wdt2_clk_en_q, k[0], "watchdog two enable");
         chk({port_hold_q, ram_retain_q}, 2'b11, "hold and retain");
         snap = step_cnt;
         apb(1'b0, `PM_OFS_STAT, 32'h0);
         chk(rd[1:0], ST_HALT, "status in halt");
         chk(step_cnt, snap, "core frozen in halt");
         req_higher_prio <= k[0];
         irq_pending     <= 1'b1;
         wait_cpu(1'b1, 4);
         {irq_pending, req_higher_prio} <= 2'b00;
         @(posedge pclk);
      end
      chk(n_ack, 2, "acknowledged wakes");
      chk(n_only, 2, "wake-only releases");
      // Reset in HALT is the ordinary reset.
      do_halt;
      other_reset_req <= 1'b1;
      wait_cpu(1'b1, 4);
      chk(sys_reset_q, 1'b1, "reset in halt");
      other_reset_req <= 1'b0;
      apb(1'b0, `PM_OFS_MODE, 32'h0);
      chk(rd, 32'h0, "mode cleared by reset");
      // STOP depth gives a request and no IDLE.
      apb(1'b1, `PM_OFS_MODE, 32'h01);
      apb(1'b1, `PM_OFS_CTRL, 32'h1);
      repeat (6) @(posedge pclk);
      chk({n_stop[1:0], cpu_clk_en_q}, 3'b011, "stop request");
      apb(1'b0, `PM_OFS_CTRL, 32'h0);
      chk(rd, 32'h0, "entry cleared");
      // IDLE released by each documented source.
      for (int k = 0; k < 4; k++) begin
         go_idle(8'h00, 4'h1);
         chk({periph_clk_en_q, wt_clk_en_q, wdt2_clk_en_q}, 3'b011, "idle enables");
         chk(ram_retain_q, 1'b1, "retain in idle");
         apb(1'b0, `PM_OFS_STAT, 32'h0);
         chk(rd[1:0], ST_IDLE, "status in idle");
         case (k)
            0: nmi_pin <= 1'b1;
            1: watchdog_two_nmi_request <= 1'b1;
            2: external_irq_pins <= 8'h80;
            default: idle_periph_irq <= 1'b1;
         endcase
         wait_cpu(1'b1, 6);
         chk(periph_clk_en_q, 1'b1, "peripheral enable back");
         {nmi_pin, watchdog_two_nmi_request, idle_periph_irq} <= 3'b000;
         external_irq_pins <= 8'h00;
         repeat (3) @(posedge pclk);
      end
      // Masked pin, watchdog one and HALT-only sources leave IDLE alone.
      go_idle(8'h00, 4'h1);
      external_irq_pins <= 8'h01;
      {wdt1_nmi, watchdog_one_reset, irq_pending} <= 3'b111;
      repeat (8) @(posedge pclk);
      chk(cpu_clk_en_q, 1'b0, "no release");
      {wdt1_nmi, watchdog_one_reset, irq_pending, other_reset_req} <= 4'b0001;
      external_irq_pins <= 8'h00;
      wait_cpu(1'b1, 6);
      chk(sys_reset_q, 1'b1, "reset releases idle");
      other_reset_req <= 1'b0;
      // Blocked NMI sources do not release IDLE; a peripheral request does.
      apb(1'b1, `PM_OFS_CTRL, 32'hC);
      go_idle(8'h00, 4'hD);
      {nmi_pin, watchdog_two_nmi_request} <= 2'b11;
      repeat (8) @(posedge pclk);
      chk(cpu_clk_en_q, 1'b0, "blocked sources");
      idle_periph_irq <= 1'b1;
      wait_cpu(1'b1, 6);
      {nmi_pin, watchdog_two_nmi_request, idle_periph_irq} <= 3'b000;
      repeat (4) @(posedge pclk);
      results;
   end
endmodule
